//--- gpio_map.svh
// register offsets, field positions, reset values and codes for the gpio port
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
`define ADDR_INPUT_A       6'h19
`define ADDR_DIRECTION_A   6'h1A
`define ADDR_OUTPUT_A      6'h1B
`define ADDR_INPUT_B       6'h16
`define ADDR_DIRECTION_B   6'h17
`define ADDR_OUTPUT_B      6'h18
`define ADDR_PC_MASK_HIGH  6'h22
`define ADDR_PC_MASK_LOW   6'h23
`define ADDR_CORE_CONTROL  6'h35
`define ADDR_EXT_FLAGS     6'h3A
`define ADDR_EXT_ENABLES   6'h3B
`define RST_PC_MASK_HIGH   8'hFF
`define RST_PC_MASK_LOW    8'hC8
`define RST_ZERO8          8'h00
`define RST_ZERO16         16'h0000
`define CORE_CONTROL_MASK  8'h7B
`define EXT_ENABLES_MASK   8'hF0
`define BIT_PULLUP_DIS     6
`define BIT_EXT_ONE        7
`define BIT_EXT_ZERO       6
`define BIT_PIN_CHANGE     5
`define BIT_GROUP_ONE      5
`define BIT_GROUP_ZERO     4
`define SENSE_LOW          2'h0
`define SENSE_CHANGE       2'h1
`define SENSE_FALL         2'h2
`define SENSE_RISE         2'h3
`define EXT_ZERO_PIN       14
`define EXT_ONE_PIN        10
`endif

//--- gpio_pkg.sv
// shared types for the gpio port
`default_nettype none
package gpio_pkg;
  // one bit per interrupt source of this block
  typedef struct packed
  {
    logic ext_one;
    logic ext_zero;
    logic pin_chg;
  } irq_set_t;
endpackage
`default_nettype wire

//--- gpio_port.sv
// two 8-bit gpio ports with external and pin-change interrupt flags
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.svh"

module gpio_port (
  input  wire logic             SYS_CLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic [5:0]       IO_ADDR_IN,
  input  wire logic             IO_WR_IN,
  input  wire logic [7:0]       IO_WDATA_IN,
  input  wire logic             IO_BIT_WR_IN,
  input  wire logic [2:0]       IO_BIT_NUM_IN,
  input  wire logic             IO_BIT_VAL_IN,
  input  wire logic             IO_RD_IN,
  output logic      [7:0]       IO_RDATA_OUT,
  input  wire logic [15:0]      PIN_IN,
  output logic      [15:0]      PIN_OUT,
  output logic      [15:0]      PIN_OE_OUT,
  output logic      [15:0]      PIN_PULLUP_OUT,
  input  wire logic             GLOBAL_IRQ_EN_IN,
  input  wire gpio_pkg::irq_set_t IRQ_ACK_IN,
  output var gpio_pkg::irq_set_t IRQ_REQ_OUT
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] out_r;       // output_register, port a low byte
  logic [15:0] dir_r;       // direction_register
  logic [7:0]  mask_low_r;
  logic [7:0]  mask_high_r;
  logic [7:0]  core_ctrl_r;
  logic [7:0]  ext_en_r;
  irq_set_t    flags_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;     // input_register value
  logic [15:0] prev_r;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic       wr_any;
  logic [7:0] wr_mask;
  logic [7:0] wr_val;
  logic [7:0] wr_ones;

  // byte writes touch all bits; bit operations only the addressed one
  always_comb
  begin
    wr_any  = IO_WR_IN | IO_BIT_WR_IN;
    wr_mask = 8'h00;
    wr_val  = 8'h00;
    if (IO_WR_IN)
    begin
      wr_mask = 8'hFF;
      wr_val  = IO_WDATA_IN;
    end
    else if (IO_BIT_WR_IN)
    begin
      wr_mask = 8'h01 << IO_BIT_NUM_IN;
      wr_val  = {8{IO_BIT_VAL_IN}};
    end
    wr_ones = wr_mask & wr_val;
  end

  // merge a write into a stored byte, keeping unaddressed bits
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] msk,
                                       input logic [7:0] val);
    merge = (cur & ~msk) | (val & msk);
  endfunction

  function automatic logic hit(input logic [5:0] addr);
    hit = wr_any && (IO_ADDR_IN == addr);
  endfunction

  // ----------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------
  // input location writes toggle output bits whatever the direction
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      out_r <= `RST_ZERO16;
    end
    else if (hit(`ADDR_OUTPUT_A))
    begin
      out_r[7:0] <= merge(out_r[7:0], wr_mask, wr_val);
    end
    else if (hit(`ADDR_OUTPUT_B))
    begin
      out_r[15:8] <= merge(out_r[15:8], wr_mask, wr_val);
    end
    else if (hit(`ADDR_INPUT_A))
    begin
      out_r[7:0] <= out_r[7:0] ^ wr_ones;
    end
    else if (hit(`ADDR_INPUT_B))
    begin
      out_r[15:8] <= out_r[15:8] ^ wr_ones;
    end
  end

  // direction registers
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      dir_r <= `RST_ZERO16;
    end
    else if (hit(`ADDR_DIRECTION_A))
    begin
      dir_r[7:0] <= merge(dir_r[7:0], wr_mask, wr_val);
    end
    else if (hit(`ADDR_DIRECTION_B))
    begin
      dir_r[15:8] <= merge(dir_r[15:8], wr_mask, wr_val);
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // masks, sense control, pull-up disable and interrupt enables
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      mask_low_r  <= `RST_PC_MASK_LOW;
      mask_high_r <= `RST_PC_MASK_HIGH;
      core_ctrl_r <= `RST_ZERO8;
      ext_en_r    <= `RST_ZERO8;
    end
    else
    begin
      if (hit(`ADDR_PC_MASK_LOW))
        mask_low_r <= merge(mask_low_r, wr_mask, wr_val);
      if (hit(`ADDR_PC_MASK_HIGH))
        mask_high_r <= merge(mask_high_r, wr_mask, wr_val);
      if (hit(`ADDR_CORE_CONTROL))
        core_ctrl_r <= merge(core_ctrl_r, wr_mask, wr_val) & `CORE_CONTROL_MASK;
      if (hit(`ADDR_EXT_ENABLES))
        ext_en_r <= merge(ext_en_r, wr_mask, wr_val) & `EXT_ENABLES_MASK;
    end
  end

  // ----------------------------------------------------------------
  // input synchronizer
  // ----------------------------------------------------------------
  // two stages against metastability; prev_r feeds change detection
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sync1_r <= `RST_ZERO16;
      sync2_r <= `RST_ZERO16;
      prev_r  <= `RST_ZERO16;
    end
    else
    begin
      sync1_r <= PIN_IN;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  logic [1:0]  sense;
  logic        level_mode;
  logic        cur_one;
  logic        cur_zero;
  logic        trig_one;
  logic        trig_zero;
  logic [15:0] pc_enable;
  logic        pc_hit;

  // one sense selection serves both external pins
  function automatic logic trig(input logic [1:0] mode,
                                input logic cur,
                                input logic old);
    case (mode)
      `SENSE_CHANGE: trig = cur ^ old;
      `SENSE_FALL:   trig = old & ~cur;
      `SENSE_RISE:   trig = ~old & cur;
      default:       trig = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    sense      = core_ctrl_r[1:0];
    level_mode = (sense == `SENSE_LOW);
    cur_one    = sync2_r[`EXT_ONE_PIN];
    cur_zero   = sync2_r[`EXT_ZERO_PIN];
    trig_one   = trig(sense, cur_one, prev_r[`EXT_ONE_PIN]);
    trig_zero  = trig(sense, cur_zero, prev_r[`EXT_ZERO_PIN]);
    // pins detect only where mask and group enable agree
    pc_enable[7:0]   = mask_low_r & {8{ext_en_r[`BIT_GROUP_ONE]}};
    pc_enable[11:8]  = mask_high_r[3:0] & {4{ext_en_r[`BIT_GROUP_ZERO]}};
    pc_enable[15:12] = mask_high_r[7:4] & {4{ext_en_r[`BIT_GROUP_ONE]}};
    pc_hit = |((sync2_r ^ prev_r) & pc_enable);
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  irq_set_t clr;
  irq_set_t flags_nxt;

  // vector entry or a written one clears; a new trigger wins
  always_comb
  begin
    clr.ext_one  = IRQ_ACK_IN.ext_one;
    clr.ext_zero = IRQ_ACK_IN.ext_zero;
    clr.pin_chg  = IRQ_ACK_IN.pin_chg;
    if (hit(`ADDR_EXT_FLAGS))
    begin
      clr.ext_one  = clr.ext_one | wr_ones[`BIT_EXT_ONE];
      clr.ext_zero = clr.ext_zero | wr_ones[`BIT_EXT_ZERO];
      clr.pin_chg  = clr.pin_chg | wr_ones[`BIT_PIN_CHANGE];
    end
    flags_nxt.ext_one  = (flags_r.ext_one & ~clr.ext_one) | trig_one;
    flags_nxt.ext_zero = (flags_r.ext_zero & ~clr.ext_zero) | trig_zero;
    flags_nxt.pin_chg  = (flags_r.pin_chg & ~clr.pin_chg) | pc_hit;
    if (level_mode)
    begin
      flags_nxt.ext_one  = 1'b0;
      flags_nxt.ext_zero = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  // ----------------------------------------------------------------
  // vector requests
  // ----------------------------------------------------------------
  // level mode requests straight from a low pin since its flag is held 0
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      IRQ_REQ_OUT <= '0;
    end
    else
    begin
      IRQ_REQ_OUT.ext_one  <= GLOBAL_IRQ_EN_IN & ext_en_r[`BIT_EXT_ONE] &
                              (level_mode ? ~cur_one : flags_r.ext_one);
      IRQ_REQ_OUT.ext_zero <= GLOBAL_IRQ_EN_IN & ext_en_r[`BIT_EXT_ZERO] &
                              (level_mode ? ~cur_zero : flags_r.ext_zero);
      IRQ_REQ_OUT.pin_chg  <= GLOBAL_IRQ_EN_IN & flags_r.pin_chg &
                              (ext_en_r[`BIT_GROUP_ONE] | ext_en_r[`BIT_GROUP_ZERO]);
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // all-zero async reset tri-states pins with no clock needed; per-pin
  // terms gate the drive with direction and the pull-up with input direction and the disable bit
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      PIN_OE_OUT     <= `RST_ZERO16;
      PIN_OUT        <= `RST_ZERO16;
      PIN_PULLUP_OUT <= `RST_ZERO16;
    end
    else
    begin
      PIN_OE_OUT     <= dir_r;
      PIN_OUT        <= out_r & dir_r;
      PIN_PULLUP_OUT <= out_r & ~dir_r &
                        {16{~core_ctrl_r[`BIT_PULLUP_DIS]}};
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rd_nxt;

  // unmapped addresses read zero
  always_comb
  begin
    case (IO_ADDR_IN)
      `ADDR_OUTPUT_A:     rd_nxt = out_r[7:0];
      `ADDR_OUTPUT_B:     rd_nxt = out_r[15:8];
      `ADDR_DIRECTION_A:  rd_nxt = dir_r[7:0];
      `ADDR_DIRECTION_B:  rd_nxt = dir_r[15:8];
      `ADDR_INPUT_A:      rd_nxt = sync2_r[7:0];
      `ADDR_INPUT_B:      rd_nxt = sync2_r[15:8];
      `ADDR_PC_MASK_LOW:  rd_nxt = mask_low_r;
      `ADDR_PC_MASK_HIGH: rd_nxt = mask_high_r;
      `ADDR_CORE_CONTROL: rd_nxt = core_ctrl_r;
      `ADDR_EXT_ENABLES:  rd_nxt = ext_en_r;
      `ADDR_EXT_FLAGS:    rd_nxt = {flags_r, 5'h00};
      default:            rd_nxt = 8'h00;
    endcase
  end

  // data holds until the next read strobe
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      IO_RDATA_OUT <= `RST_ZERO8;
    else if (IO_RD_IN)
      IO_RDATA_OUT <= rd_nxt;
  end

endmodule
`default_nettype wire

//--- gpio_port_properties.sv
// concurrent checks on the gpio port top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.svh"
module gpio_port_checker (
  input wire logic               SYS_CLK_IN,
  input wire logic               RST_N_IN,
  input wire logic [5:0]         IO_ADDR_IN,
  input wire logic               IO_WR_IN,
  input wire logic [7:0]         IO_WDATA_IN,
  input wire logic               IO_RD_IN,
  input wire logic [7:0]         IO_RDATA_OUT,
  input wire logic [15:0]        PIN_IN,
  input wire logic [15:0]        PIN_OUT,
  input wire logic [15:0]        PIN_OE_OUT,
  input wire logic [15:0]        PIN_PULLUP_OUT,
  input wire logic               GLOBAL_IRQ_EN_IN,
  input wire gpio_pkg::irq_set_t IRQ_ACK_IN,
  input wire gpio_pkg::irq_set_t IRQ_REQ_OUT
);
  import gpio_pkg::*;
  // ----------------------------------------
  // pin and register relations
  // ----------------------------------------
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // reset must float pins with no clock help, so no disable here
  reset_tristate_a: assert property (disable iff (1'b0) !RST_N_IN |-> PIN_OE_OUT == 16'h0000
    && PIN_PULLUP_OUT == 16'h0000) else $error("pins active in reset");
  drive_no_pullup_a: assert property ((PIN_OE_OUT & PIN_PULLUP_OUT) == 16'h0000)
    else $error("pull-up on driven pin");
  input_quiet_a: assert property ((PIN_OUT & ~PIN_OE_OUT) == 16'h0000)
    else $error("drive value on input pin");
  reserved_zero_a: assert property (IO_RD_IN && IO_ADDR_IN == `ADDR_EXT_FLAGS |=> IO_RDATA_OUT[4:0] == 5'h00)
    else $error("reserved flag bits set");
  unmapped_zero_a: assert property (IO_RD_IN && IO_ADDR_IN == 6'h00 |=> IO_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  pud_blocks_a: assert property (IO_WR_IN && IO_ADDR_IN == `ADDR_CORE_CONTROL && IO_WDATA_IN[6]
    |-> ##2 PIN_PULLUP_OUT == 16'h0000) else $error("pull-up despite disable");
  dir_to_oe_a: assert property (IO_WR_IN && IO_ADDR_IN == `ADDR_DIRECTION_A
    |-> ##2 PIN_OE_OUT[7:0] == $past(IO_WDATA_IN, 2)) else $error("enable differs from direction");
  ack_clears_a: assert property ($stable(PIN_IN) [*4] ##0 IRQ_ACK_IN.pin_chg
    |-> ##2 !IRQ_REQ_OUT.pin_chg) else $error("request after ack");
  gate_global_a: assert property (!GLOBAL_IRQ_EN_IN |=> IRQ_REQ_OUT == 3'b000)
    else $error("request without global enable");
endmodule
bind gpio_port gpio_port_checker gpio_port_checker_inst (.SYS_CLK_IN, .RST_N_IN, .IO_ADDR_IN, .IO_WR_IN,
  .IO_WDATA_IN, .IO_RD_IN, .IO_RDATA_OUT, .PIN_IN, .PIN_OUT, .PIN_OE_OUT, .PIN_PULLUP_OUT,
  .GLOBAL_IRQ_EN_IN, .IRQ_ACK_IN, .IRQ_REQ_OUT);
`default_nettype wire

//--- pin_partner.sv
// pin-side model: external drivers, pull-ups and released lines
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic        clk_in,
  input  wire logic [15:0] oe_in,
  input  wire logic [15:0] drive_in,
  input  wire logic [15:0] pullup_in,
  input  wire logic [15:0] ext_en_in,
  input  wire logic [15:0] ext_val_in,
  output logic      [15:0] pin_out
);
  logic [15:0] held_r = 16'h0000;
  logic [15:0] free_w;
  // a released line shows the inverse of its last level, never a lucky match
  assign free_w = ~oe_in & ~ext_en_in & ~pullup_in;
  always_comb
    pin_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in) |
              (~oe_in & ~ext_en_in & pullup_in) | (free_w & ~held_r);
  // remember the level while something holds the line
  always_ff @(posedge clk_in)
    held_r <= (held_r & free_w) | (pin_out & ~free_w);
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the gpio port
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.svh"
module tb_top;
  import gpio_pkg::*;
  logic clk, rst_n, wr, bw, bv, rd, gie, global_pullup_disable;
  logic [5:0] addr;
  logic [7:0] wd, rdata, v;
  logic [2:0] bn;
  logic [15:0] pin, pout, oe, pu, xen, xval, dir, outv, m;
  irq_set_t ack, req;
  int n_mismatch, n_checks, seed, i, s;
  logic [13:0] rst_tab [6] = '{{`ADDR_PC_MASK_HIGH, `RST_PC_MASK_HIGH}, {`ADDR_PC_MASK_LOW, `RST_PC_MASK_LOW},
    {`ADDR_EXT_FLAGS, 8'h00}, {`ADDR_DIRECTION_A, 8'h00}, {`ADDR_OUTPUT_B, 8'h00}, {6'h00, 8'h00}};
  // enables, expected flag at bit 4, pin number in the low nibble
  logic [15:0] pc_tab [6] = '{16'h1003, 16'h1019, 16'h2013, 16'h201C, 16'h2009, 16'h3002};
  gpio_port gpio_port_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .IO_ADDR_IN(addr), .IO_WR_IN(wr), .IO_WDATA_IN(wd),
    .IO_BIT_WR_IN(bw), .IO_BIT_NUM_IN(bn), .IO_BIT_VAL_IN(bv), .IO_RD_IN(rd), .IO_RDATA_OUT(rdata), .PIN_IN(pin),
    .PIN_OUT(pout), .PIN_OE_OUT(oe), .PIN_PULLUP_OUT(pu), .GLOBAL_IRQ_EN_IN(gie), .IRQ_ACK_IN(ack), .IRQ_REQ_OUT(req));
  pin_partner pin_partner_inst (.clk_in(clk), .oe_in(oe), .drive_in(pout), .pullup_in(pu), .ext_en_in(xen),
    .ext_val_in(xval), .pin_out(pin));
  // ----------------------------------------
  // clock, tasks and expectations
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bit_op(input logic [5:0] a, input logic [2:0] b, input logic val);
    @(posedge clk);
    addr <= a;
    bn <= b;
    bv <= val;
    bw <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
  endtask
  // read data stands from the taking edge; pick it up one edge later so the
  // caller keeps driving on rising edges only
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] ext_exp(input int sc, input logic fall);
    logic e;
    e = (sc == `SENSE_CHANGE) || (sc == `SENSE_FALL && fall) || (sc == `SENSE_RISE && !fall);
    return {e, e, 6'h00};
  endfunction
  // hang guard: nothing here waits on the design, so this only trips on a stuck run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  // main sequence
  initial
  begin
    seed = 32'h2063;
    {rst_n, wr, bw, bv, rd, gie, addr, wd, bn, xen, xval} = '0;
    ack = '0;
    repeat (16) @(posedge clk);
    chk(oe === 16'h0000 && pu === 16'h0000, "pins active in reset");
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      rd_reg(rst_tab[i][13:8], v);
      chk(v === rst_tab[i][7:0], "reset value");
    end
    $display("test reset done");
    for (i = 0; i < 20; i++)
    begin
      outv = 16'($random(seed));
      dir = 16'($random(seed));
      global_pullup_disable = 1'($random(seed));
      if (i < 2)
        {dir, outv, global_pullup_disable} = {{16{i[0]}}, 16'hFFFF, 1'b0};
      wr_reg(`ADDR_CORE_CONTROL, {1'b0, global_pullup_disable, 6'h00});
      wr_reg(`ADDR_OUTPUT_A, outv[7:0]);
      wr_reg(`ADDR_OUTPUT_B, outv[15:8]);
      wr_reg(`ADDR_DIRECTION_A, dir[7:0]);
      wr_reg(`ADDR_DIRECTION_B, dir[15:8]);
      repeat (3) @(posedge clk);
      chk(oe === dir && pout === (dir & outv), "pin drive");
      chk(pu === (~dir & outv & {16{~global_pullup_disable}}), "pull-up");
      m = dir | (outv & {16{~global_pullup_disable}});
      rd_reg(`ADDR_INPUT_A, v);
      chk((v & m[7:0]) === (outv[7:0] & m[7:0]), "input a");
      rd_reg(`ADDR_INPUT_B, v);
      chk((v & m[15:8]) === (outv[15:8] & m[15:8]), "input b");
    end
    $display("test pins done");
    wr_reg(`ADDR_OUTPUT_A, 8'h5A);
    wr_reg(`ADDR_INPUT_A, 8'h0F);
    rd_reg(`ADDR_OUTPUT_A, v);
    chk(v === 8'h55, "toggle");
    bit_op(`ADDR_INPUT_A, 3'h7, 1'b1);
    bit_op(`ADDR_INPUT_A, 3'h1, 1'b0);
    bit_op(`ADDR_OUTPUT_A, 3'h0, 1'b0);
    bit_op(`ADDR_DIRECTION_A, 3'h2, 1'b1);
    rd_reg(`ADDR_OUTPUT_A, v);
    chk(v === 8'hD4, "bit ops output");
    rd_reg(`ADDR_DIRECTION_A, v);
    chk(v === (dir[7:0] | 8'h04), "bit op direction");
    $display("test bit ops done");
    // all pins become inputs held by the outside
    wr_reg(`ADDR_DIRECTION_A, 8'h00);
    wr_reg(`ADDR_DIRECTION_B, 8'h00);
    wr_reg(`ADDR_CORE_CONTROL, 8'h40);
    xen <= 16'hFFFF;
    for (i = 0; i < 6; i++)
    begin
      wr_reg(`ADDR_EXT_ENABLES, pc_tab[i][15:8]);
      repeat (6) @(posedge clk);
      wr_reg(`ADDR_EXT_FLAGS, 8'hE0);
      xval[pc_tab[i][3:0]] <= ~xval[pc_tab[i][3:0]];
      repeat (6) @(posedge clk);
      rd_reg(`ADDR_EXT_FLAGS, v);
      chk(v === {2'b00, pc_tab[i][4], 5'h00}, "pin change flag");
    end
    gie <= 1'b1;
    xval[12] <= ~xval[12];
    repeat (6) @(posedge clk);
    chk(req.pin_chg === 1'b1, "no request");
    ack.pin_chg <= 1'b1;
    @(posedge clk);
    ack.pin_chg <= 1'b0;
    repeat (2) @(posedge clk);
    chk(req.pin_chg === 1'b0, "ack left request");
    xval[12] <= ~xval[12];
    repeat (6) @(posedge clk);
    wr_reg(`ADDR_EXT_FLAGS, 8'h20);
    rd_reg(`ADDR_EXT_FLAGS, v);
    chk(v === 8'h00, "write one clear");
    gie <= 1'b0;
    $display("test pin change done");
    wr_reg(`ADDR_EXT_ENABLES, 8'hC0);
    for (i = 0; i < 8; i++)
    begin
      s = i >> 1;
      {xval[10], xval[14]} <= {2{i[0]}};
      wr_reg(`ADDR_CORE_CONTROL, 8'(s));
      repeat (6) @(posedge clk);
      wr_reg(`ADDR_EXT_FLAGS, 8'hE0);
      {xval[10], xval[14]} <= {2{~i[0]}};
      repeat (6) @(posedge clk);
      rd_reg(`ADDR_EXT_FLAGS, v);
      chk(v === ext_exp(s, i[0]), "external flags");
    end
    // rising sense left in place: both external pins raise vector requests
    gie <= 1'b1;
    {xval[10], xval[14]} <= 2'b11;
    repeat (6) @(posedge clk);
    chk(req === 3'b110, "no edge request");
    ack <= 3'b110;
    @(posedge clk);
    ack <= 3'b000;
    repeat (2) @(posedge clk);
    chk(req === 3'b000, "ack left edge request");
    // level sensing requests straight from a low pin
    wr_reg(`ADDR_CORE_CONTROL, {6'h00, `SENSE_LOW});
    {xval[10], xval[14]} <= 2'b00;
    repeat (6) @(posedge clk);
    chk(req === 3'b110, "no level request");
    {xval[10], xval[14]} <= 2'b11;
    repeat (6) @(posedge clk);
    chk(req === 3'b000, "level request stuck");
    gie <= 1'b0;
    $display("test external edges done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(oe === 16'h0000 && pu === 16'h0000, "pins active in reset");
    rst_n <= 1'b1;
    rd_reg(`ADDR_PC_MASK_LOW, v);
    chk(v === `RST_PC_MASK_LOW, "mask after reset");
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
